// file: logic/lsl_pkg.sv
package lsl_pkg;
    // ----------------------------------------------------------------
    // transfer lengths
    // ----------------------------------------------------------------
    localparam logic [5:0] LSL_LEN_SETUP     = 6'h08;
    localparam logic [5:0] LSL_LEN_VCO       = 6'h10;
    localparam logic [5:0] LSL_LEN_XTAL_S    = 6'h0F;
    localparam logic [5:0] LSL_LEN_XTAL_L    = 6'h18;
    localparam logic [5:0] LSL_LEN_RST_LO    = 6'h09;
    localparam logic [5:0] LSL_LEN_RST_HI    = 6'h0D;
    localparam logic [5:0] LSL_LEN_MAX       = 6'h20;
    // ----------------------------------------------------------------
    // register widths and reset values
    // ----------------------------------------------------------------
    localparam int         LSL_SETUP_W       = 8;
    localparam int         LSL_VCO_W         = 16;
    localparam int         LSL_XTAL_W        = 15;
    localparam int         LSL_SHIFT_W       = 24;
    localparam logic [7:0] LSL_SETUP_RST     = 8'h00;
    localparam logic [15:0] LSL_VCO_RST      = 16'h0000;
    localparam logic [14:0] LSL_XTAL_RST     = 15'h0000;

    typedef enum logic [2:0] {
        LSL_TGT_NONE,
        LSL_TGT_SETUP,
        LSL_TGT_VCO,
        LSL_TGT_XTAL,
        LSL_TGT_RESET
    } lsl_target_t;
endpackage

// file: logic/lsl_sync.sv
module lsl_sync
    import lsl_pkg::*;
(
    input  wire logic       sys_clk_i,   // system clock
    input  wire logic       reset_n_i,   // async reset, active low
    input  wire logic       clk_en_i,    // clock enable
    input  wire logic [2:0] async_i,     // pin levels
    output logic      [2:0] sync_o       // synchronised levels
);
    logic [2:0] meta_q;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // idle pin levels: gate high, clock low, so no false edge
            meta_q <= 3'h4;
            sync_o <= 3'h4;
        end else if (clk_en_i) begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// file: logic/lsl_loader.sv
// Overview of operation
// - sample data into shift register on each serial clock rise while gate low and port armed
// - eight clocked bits load the setup word
// - sixteen clocked bits load the vco divisor
// - twenty-four clocked bits write the crystal divider register
// - fifteen clocked bits also write the crystal divider register
// - registers hold while shifting, update only at gate release
// - destination chosen purely by bit count, no address bits
// - registers may be written in any order
// - nine to thirteen bits form the reset pattern, no register write
// - words arrive msb first, last bit is bit zero
// - gate rising edge commits shifted word by length when port armed
// - gate high inhibits shifting, floats serial output, holds port initialised
// - serial output shifts on each serial clock fall while port armed
module lsl_loader
    import lsl_pkg::*;
(
    input  wire logic        sys_clk_i,         // system clock
    input  wire logic        reset_n_i,         // async reset, active low
    input  wire logic        clk_en_i,          // clock enable
    input  wire logic        serial_clk_i,      // serial clock pin
    input  wire logic        serial_din_i,      // serial data in pin
    input  wire logic        transfer_gate_n_i, // gate pin, active low
    output logic             serial_dout_o,     // serial data out
    output logic             serial_dout_oe_n_o,// dout enable, low drives
    output logic [7:0]       setup_word_o,      // setup word register
    output logic [15:0]      vco_divisor_o,     // vco divisor register
    output logic [14:0]      xtal_divide_o,     // crystal divider register
    output logic             reset_pattern_o    // pulse on reset pattern
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic       sclk_s;
    logic       din_s;
    logic       gate_n_s;

    lsl_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .clk_en_i  (clk_en_i),
        .async_i   ({transfer_gate_n_i, serial_din_i, serial_clk_i}),
        .sync_o    (pins_s)
    );

    assign sclk_s   = pins_s[0];
    assign din_s    = pins_s[1];
    assign gate_n_s = pins_s[2];

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic sclk_q;
    logic gate_n_q;
    logic sclk_rise;
    logic sclk_fall;
    logic gate_rise;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q   <= 1'b0;
            gate_n_q <= 1'b1;
        end else if (clk_en_i) begin
            sclk_q   <= sclk_s;
            gate_n_q <= gate_n_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_q;
    assign sclk_fall = !sclk_s && sclk_q;
    assign gate_rise = gate_n_s && !gate_n_q;

    // ----------------------------------------------------------------
    // length decode
    // ----------------------------------------------------------------
    function automatic lsl_target_t lsl_decode(input logic [5:0] len);
        lsl_target_t t;
        t = LSL_TGT_NONE;
        if (len == LSL_LEN_SETUP) begin
            t = LSL_TGT_SETUP;
        end else if (len == LSL_LEN_VCO) begin
            t = LSL_TGT_VCO;
        end else if (len == LSL_LEN_XTAL_S || len == LSL_LEN_XTAL_L) begin
            t = LSL_TGT_XTAL;
        end else if (len >= LSL_LEN_RST_LO && len <= LSL_LEN_RST_HI) begin
            t = LSL_TGT_RESET;
        end
        return t;
    endfunction

    // ----------------------------------------------------------------
    // port state: arms only on a gate fall seen with the clock low
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LSL_PORT_IDLE,
        LSL_PORT_ARMED,
        LSL_PORT_LOCKED
    } lsl_port_t;

    lsl_port_t port_q;
    logic      gate_fall;
    logic      armed;

    assign gate_fall = !gate_n_s && gate_n_q;
    assign armed     = (port_q == LSL_PORT_ARMED);

    // gate fall with clock high locks the port out until gate high
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            port_q <= LSL_PORT_IDLE;
        end else if (clk_en_i) begin
            case (port_q)
                LSL_PORT_IDLE: begin
                    if (gate_fall && !sclk_s) begin
                        port_q <= LSL_PORT_ARMED;
                    end else if (gate_fall) begin
                        port_q <= LSL_PORT_LOCKED;
                    end
                end
                LSL_PORT_ARMED: begin
                    if (gate_n_s) begin
                        port_q <= LSL_PORT_IDLE;
                    end
                end
                LSL_PORT_LOCKED: begin
                    if (gate_n_s) begin
                        port_q <= LSL_PORT_IDLE;
                    end
                end
                default: begin
                    port_q <= LSL_PORT_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // shift register and bit count
    // ----------------------------------------------------------------
    logic [LSL_SHIFT_W-1:0] shift_q;
    logic [5:0]             count_q;
    logic                   shift_en;

    assign shift_en = armed && !gate_n_s && sclk_rise;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_q <= '0;
        end else if (clk_en_i && shift_en) begin
            // msb first: new bit enters at bit 0
            shift_q <= {shift_q[LSL_SHIFT_W-2:0], din_s};
        end
    end

    // count held at zero while gate high, read once at gate rise
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_q <= 6'h00;
        end else if (clk_en_i) begin
            if (gate_n_s) begin
                count_q <= 6'h00;
            end else if (shift_en && count_q != 6'h3F) begin
                count_q <= count_q + 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            serial_dout_o      <= 1'b0;
            serial_dout_oe_n_o <= 1'b1;
        end else if (clk_en_i) begin
            if (gate_n_s || !armed) begin
                serial_dout_oe_n_o <= 1'b1;
            end else if (sclk_fall) begin
                serial_dout_o      <= shift_q[LSL_VCO_W-1];
                serial_dout_oe_n_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // commit on gate release
    // ----------------------------------------------------------------
    lsl_target_t target;
    logic        commit;

    assign target = lsl_decode(count_q);
    assign commit = gate_rise && armed && (count_q <= LSL_LEN_MAX);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            setup_word_o <= LSL_SETUP_RST;
        end else if (clk_en_i && commit && target == LSL_TGT_SETUP) begin
            setup_word_o <= shift_q[LSL_SETUP_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vco_divisor_o <= LSL_VCO_RST;
        end else if (clk_en_i && commit && target == LSL_TGT_VCO) begin
            vco_divisor_o <= shift_q[LSL_VCO_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            xtal_divide_o <= LSL_XTAL_RST;
        end else if (clk_en_i && commit && target == LSL_TGT_XTAL) begin
            xtal_divide_o <= shift_q[LSL_XTAL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_pattern_o <= 1'b0;
        end else if (clk_en_i) begin
            reset_pattern_o <= commit && target == LSL_TGT_RESET;
        end
    end
endmodule

// file: sim/lsl_host_model.sv
module lsl_host_model (
    output logic sclk_o,    // serial clock
    output logic din_o,     // serial data
    output logic gate_n_o   // transfer gate, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sclk_o = 1'b0;
        din_o = 1'b1;
        gate_n_o = 1'b1;
    end
    // ----------------------------------------------------------------
    // one frame, msb first, gate moves only while clock low, except that with skew set the gate falls with clock high
    // ----------------------------------------------------------------
    task automatic send(input logic [31:0] word, input int len, input logic skew);
        if (skew) begin
            sclk_o = 1'b1;                  // gate falls with clock high
        end
        #13 gate_n_o = 1'b0;
        for (int i = len - 1; i >= 0; i--) begin
            din_o = word[i];
            #160 sclk_o = 1'b1;
            #160 sclk_o = 1'b0;
        end
        #160 gate_n_o = 1'b1;
        din_o = ~din_o;
    endtask
endmodule

// file: sim/lsl_loader_properties.sv
module lsl_loader_properties (
    input wire logic        sys_clk_i,          // clock
    input wire logic        reset_n_i,          // reset
    input wire logic        clk_en_i,           // enable
    input wire logic        serial_clk_i,       // sclk
    input wire logic        serial_din_i,       // din
    input wire logic        transfer_gate_n_i,  // gate
    input wire logic        serial_dout_o,      // dout
    input wire logic        serial_dout_oe_n_o, // dout enable
    input wire logic [7:0]  setup_word_o,       // setup
    input wire logic [15:0] vco_divisor_o,      // vco
    input wire logic [14:0] xtal_divide_o,      // xtal
    input wire logic        reset_pattern_o     // pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence gate_low_s; (!transfer_gate_n_i)[*5]; endsequence
    sequence gate_high_s; transfer_gate_n_i[*5]; endsequence
    hold_shift_a: assert property (gate_low_s |-> $stable({setup_word_o, vco_divisor_o, xtal_divide_o}))
        else $error("register moved while shifting");
    float_idle_a: assert property (gate_high_s |-> serial_dout_oe_n_o)
        else $error("output driven while gate high");
    pulse_once_a: assert property (reset_pattern_o |=> !reset_pattern_o)
        else $error("reset pulse too long");
    pulse_quiet_a: assert property (reset_pattern_o |-> transfer_gate_n_i && $stable({setup_word_o, vco_divisor_o, xtal_divide_o}))
        else $error("reset pattern touched registers");
    commit_gate_a: assert property (!$stable({setup_word_o, vco_divisor_o, xtal_divide_o}) |-> transfer_gate_n_i)
        else $error("register changed with gate low");
    freeze_en_a: assert property ((!clk_en_i)[*2] |-> $stable({setup_word_o, vco_divisor_o, xtal_divide_o, serial_dout_oe_n_o}))
        else $error("state moved while disabled");
    dout_fall_a: assert property ($changed(serial_dout_o) |-> !serial_clk_i)
        else $error("dout moved with clock high");
    oe_fall_a: assert property ($fell(serial_dout_oe_n_o) |-> !transfer_gate_n_i && !serial_clk_i)
        else $error("dout enabled outside falling edge");
endmodule

// file: sim/testbench.sv
module testbench;
    import lsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i, reset_n_i, clk_en_i, sclk, din, gate_n, dout, oe_n, pulse;
    logic [7:0] setup;
    logic [15:0] vco;
    logic [14:0] xtal;
    int fails = 0, samples_checked = 0, pulses = 0;
    int exp_s = LSL_SETUP_RST, exp_v = LSL_VCO_RST, exp_x = LSL_XTAL_RST;
    logic skew = 1'b0;
    logic [15:0] hist;
    int lens [8] = '{8, 16, 15, 24, 9, 13, 5, 20};
    lsl_host_model host_u (.sclk_o(sclk), .din_o(din), .gate_n_o(gate_n));
    lsl_loader dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .serial_clk_i(sclk), .serial_din_i(din), .transfer_gate_n_i(gate_n),
        .serial_dout_o(dout), .serial_dout_oe_n_o(oe_n), .setup_word_o(setup),
        .vco_divisor_o(vco), .xtal_divide_o(xtal), .reset_pattern_o(pulse));
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) if (pulse === 1'b1) pulses++;
    // ----------------------------------------------------------------
    // shift-history model: dout shows stage 15 after each clock fall
    // ----------------------------------------------------------------
    always @(posedge sclk or negedge reset_n_i) begin
        if (!reset_n_i) hist = 16'h0000;
        else if (!skew) hist = {hist[14:0], din};
    end
    always @(negedge sclk) begin
        #120;
        if (reset_n_i === 1'b1) begin
            check(oe_n, skew);
            if (!skew) check(dout, hist[15]);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // random frames of every length class, any order
    // ----------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0;
        clk_en_i = 1'b1;
        void'($urandom(53));
        repeat (6) @(posedge sys_clk_i);
        #3 reset_n_i = 1'b1;
        for (int k = 0; k < 24; k++) begin
            automatic int len = lens[($urandom % 8)];
            automatic logic [31:0] w = $urandom;
            repeat (8) @(posedge sys_clk_i);
            #3 clk_en_i = (k % 7 != 3);
            repeat (4) @(posedge sys_clk_i);
            #3 clk_en_i = 1'b1;
            if (k == 12) begin
                reset_n_i = 1'b0;
                repeat (2) @(posedge sys_clk_i);
                #3 reset_n_i = 1'b1;
                exp_s = LSL_SETUP_RST;
                exp_v = LSL_VCO_RST;
                exp_x = LSL_XTAL_RST;
                check(setup, exp_s);
                check(vco, exp_v);
                check(xtal, exp_x);
                check(oe_n, 1'b1);
                repeat (6) @(posedge sys_clk_i);
                #3;
            end
            skew = (k % 5 == 4);
            pulses = 0;
            host_u.send(w, len, skew);
            repeat (10) @(posedge sys_clk_i);
            #3;
            if (!skew) begin
                case (len)
                    8: exp_s = w[7:0];
                    16: exp_v = w[15:0];
                    15, 24: exp_x = w[14:0];
                    default: ;
                endcase
            end
            check(setup, exp_s);
            check(vco, exp_v);
            check(xtal, exp_x);
            check(oe_n, 1'b1);
            check(pulses, !skew && len >= 9 && len <= 13);
        end
        end_sim();
    end
    initial begin
        #1000000;
        fails++;
        end_sim();
    end
endmodule
bind lsl_loader lsl_loader_properties chk_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .serial_clk_i(serial_clk_i), .serial_din_i(serial_din_i),
    .transfer_gate_n_i(transfer_gate_n_i), .serial_dout_o(serial_dout_o),
    .serial_dout_oe_n_o(serial_dout_oe_n_o), .setup_word_o(setup_word_o),
    .vco_divisor_o(vco_divisor_o), .xtal_divide_o(xtal_divide_o),
    .reset_pattern_o(reset_pattern_o));
